// ### design/tprs_pkg.sv
// package of constants for the transmit power ramp shaper
package tprs_pkg;
  localparam int          TPRS_ENTRIES    = 8;
  localparam int          TPRS_IDX_W      = 3;
  localparam int          TPRS_PWR_W      = 8;
  localparam logic [7:0]  TPRS_PWR_RESET  = 8'hc6;
  localparam int          TPRS_SUBSTEPS   = 8;
  localparam logic [2:0]  TPRS_IDX_ZERO   = 3'h0;
  localparam logic [2:0]  TPRS_IDX_ONE    = 3'h1;

  typedef enum logic [1:0] {
    TPRS_OFF  = 2'b00,
    TPRS_UP   = 2'b01,
    TPRS_HOLD = 2'b10,
    TPRS_DOWN = 2'b11
  } tprs_state_t;
endpackage

// ### design/tprs_shaper.sv
// transmit power ramp and ask shaping selector
// Contract
// - eight-entry power table, 3-bit top index
// - ramp index 0 up to top, back down
// - ask counter up on one, down zero
// - counter steps eight times per symbol
// - counter saturates at top and zero; indexes
// - table resets to 0xc6
`timescale 1ns/100ps
`default_nettype none
module tprs_shaper
  import tprs_pkg::*;
#(
  parameter int N_ENTRIES = TPRS_ENTRIES
) (
  input  wire logic                  sys_clk,          // 10 mhz clock
  input  wire logic                  reset_n,          // async reset, active low
  input  wire logic                  tbl_wr_en,        // table write strobe
  input  wire logic [TPRS_IDX_W-1:0] tbl_wr_idx,       // entry written
  input  wire logic [TPRS_PWR_W-1:0] tbl_wr_data,      // value written
  input  wire logic [TPRS_IDX_W-1:0] ramp_top_index,   // highest entry used
  input  wire logic                  ask_mode,         // ask shaping on
  input  wire logic                  tx_active,        // transmission in progress
  input  wire logic                  sub_tick,         // 8x symbol rate strobe
  input  wire logic                  tx_symbol,        // current symbol value
  output logic [TPRS_PWR_W-1:0]      amp_setting_word, // amplifier word
  output logic [TPRS_IDX_W-1:0]      cur_index         // selected entry
);
  // ------------------------------------------------------------
  // power level table
  // ------------------------------------------------------------
  logic [TPRS_PWR_W-1:0] power_level_table_reg  [N_ENTRIES];
  logic [TPRS_PWR_W-1:0] power_level_table_next [N_ENTRIES];

  always_comb begin
    for (int i = 0; i < N_ENTRIES; i++) begin
      power_level_table_next[i] = power_level_table_reg[i];
    end
    if (tbl_wr_en) begin
      power_level_table_next[tbl_wr_idx] = tbl_wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < N_ENTRIES; i++) begin
        power_level_table_reg[i] <= TPRS_PWR_RESET;
      end
    end else begin
      for (int i = 0; i < N_ENTRIES; i++) begin
        power_level_table_reg[i] <= power_level_table_next[i];
      end
    end
  end

  // ------------------------------------------------------------
  // ramp sequencer and shaping counter
  // ------------------------------------------------------------
  tprs_state_t           state_reg, state_next;
  logic [TPRS_IDX_W-1:0] idx_reg, idx_next;
  logic [TPRS_IDX_W-1:0] idx_base;
  logic [TPRS_PWR_W-1:0] pwr_reg, pwr_next;

  // ------------------------------------------------------------
  // index arithmetic; the steps are shared by ramp and shaping paths, the clamp is used by the ramp only
  // ------------------------------------------------------------
  // one step towards top; an index above top falls back to top
  function automatic logic [TPRS_IDX_W-1:0] idx_step_up(
    input logic [TPRS_IDX_W-1:0] idx,
    input logic [TPRS_IDX_W-1:0] top
  );
    if (idx < top) begin
      return idx + TPRS_IDX_ONE;
    end else begin
      return top;
    end
  endfunction

  // one step towards zero, saturating there
  function automatic logic [TPRS_IDX_W-1:0] idx_step_down(
    input logic [TPRS_IDX_W-1:0] idx
  );
    if (idx != TPRS_IDX_ZERO) begin
      return idx - TPRS_IDX_ONE;
    end else begin
      return TPRS_IDX_ZERO;
    end
  endfunction

  // pulls a stale index back under a lowered top
  function automatic logic [TPRS_IDX_W-1:0] idx_clamp(
    input logic [TPRS_IDX_W-1:0] idx,
    input logic [TPRS_IDX_W-1:0] top
  );
    if (idx > top) begin
      return top;
    end else begin
      return idx;
    end
  endfunction

  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    idx_base   = idx_clamp(idx_reg, ramp_top_index);
    if (ask_mode) begin
      state_next = TPRS_OFF;
      if (sub_tick) begin
        if (tx_symbol) begin
          idx_next = idx_step_up(idx_reg, ramp_top_index);
        end else begin
          idx_next = idx_step_down(idx_reg);
        end
      end
    end else begin
      unique case (state_reg)
        TPRS_OFF: begin
          idx_next = TPRS_IDX_ZERO;
          if (tx_active) begin
            state_next = (ramp_top_index == TPRS_IDX_ZERO) ? TPRS_HOLD : TPRS_UP;
          end
        end
        TPRS_UP: begin
          idx_next = idx_base;
          if (!tx_active) begin
            state_next = TPRS_DOWN;
          end else if (sub_tick) begin
            idx_next = idx_step_up(idx_base, ramp_top_index);
            if (idx_next == ramp_top_index) begin
              state_next = TPRS_HOLD;
            end
          end
        end
        TPRS_HOLD: begin
          idx_next = idx_base;
          if (!tx_active) begin
            state_next = (idx_base == TPRS_IDX_ZERO) ? TPRS_OFF : TPRS_DOWN;
          end
        end
        TPRS_DOWN: begin
          idx_next = idx_base;
          if (tx_active) begin
            state_next = TPRS_UP;
          end else if (sub_tick) begin
            idx_next = idx_step_down(idx_base);
            if (idx_base <= TPRS_IDX_ONE) begin
              state_next = TPRS_OFF;
            end
          end
        end
      endcase
    end
    // next table contents, so a write to the selected entry shows at once
    pwr_next = power_level_table_next[idx_next];
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= TPRS_OFF;
      idx_reg   <= TPRS_IDX_ZERO;
      pwr_reg   <= TPRS_PWR_RESET;
    end else begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      pwr_reg   <= pwr_next;
    end
  end

  assign amp_setting_word = pwr_reg;
  assign cur_index        = idx_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_TABLE_OUT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ##1 amp_setting_word == power_level_table_reg[cur_index])
    else $error("amplifier word differs from selected entry");
  AST_ASK_UP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ask_mode && sub_tick && tx_symbol && cur_index < ramp_top_index
    |=> cur_index == $past(cur_index) + 3'h1)
    else $error("ask counter failed to count up");
  AST_ASK_DOWN: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ask_mode && sub_tick && !tx_symbol && cur_index != 3'h0
    |=> cur_index == $past(cur_index) - 3'h1)
    else $error("ask counter failed to count down");
  AST_ASK_IDLE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ask_mode && !sub_tick && $stable(ramp_top_index) && cur_index <= ramp_top_index
    |=> $stable(cur_index))
    else $error("ask counter moved without a step strobe");
  AST_ASK_SAT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ask_mode && sub_tick && tx_symbol && cur_index == ramp_top_index
    |=> cur_index == $past(ramp_top_index))
    else $error("ask counter passed top index");
  AST_RAMP_TOP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !ask_mode && tx_active && $stable(ramp_top_index) |-> cur_index <= ramp_top_index)
    else $error("ramp index above top");
  AST_RAMP_STEP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !ask_mode && $past(!ask_mode) |-> cur_index == $past(cur_index)
      || cur_index == $past(cur_index) + 3'h1 || cur_index == $past(cur_index) - 3'h1
      || cur_index == $past(ramp_top_index) || cur_index == 3'h0)
    else $error("ramp skipped an entry");
  AST_RAMP_DONE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_reg == TPRS_OFF && !ask_mode |=> cur_index == 3'h0)
    else $error("idle index not zero");
  AST_WRITE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tbl_wr_en |=> power_level_table_reg[$past(tbl_wr_idx)] == $past(tbl_wr_data))
    else $error("table write lost");
  AST_RAMP_START: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !ask_mode && state_reg == TPRS_OFF && tx_active && ramp_top_index != TPRS_IDX_ZERO
    |=> state_reg == TPRS_UP && cur_index == TPRS_IDX_ZERO)
    else $error("ramp did not start from entry zero");
  AST_RAMP_FLAT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !ask_mode && state_reg == TPRS_OFF && tx_active && ramp_top_index == TPRS_IDX_ZERO
    |=> state_reg == TPRS_HOLD && cur_index == TPRS_IDX_ZERO)
    else $error("zero top did not hold entry zero");
  AST_RAMP_UP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !ask_mode && state_reg == TPRS_UP && tx_active && sub_tick && cur_index < ramp_top_index
    |=> cur_index == $past(cur_index) + TPRS_IDX_ONE)
    else $error("ramp up missed a step");
  AST_RAMP_DOWN: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !ask_mode && state_reg == TPRS_DOWN && !tx_active && sub_tick && cur_index != TPRS_IDX_ZERO
    && cur_index <= ramp_top_index |=> cur_index == $past(cur_index) - TPRS_IDX_ONE)
    else $error("ramp down missed a step");
endmodule // tprs_shaper
`default_nettype wire

// ### sim/tprs_pa_model.sv
// model of the amplifier power setting input
`timescale 1ns/100ps
`default_nettype none
module tprs_pa_model
  import tprs_pkg::*;
(
  input  wire logic                  sys_clk,  // modem clock
  input  wire logic [TPRS_PWR_W-1:0] pwr_word, // setting from the selector
  output logic      [TPRS_PWR_W-1:0] applied   // setting taken by the amplifier
);
  always_ff @(posedge sys_clk) begin
    applied <= pwr_word;
  end
endmodule // tprs_pa_model
`default_nettype wire

// ### sim/test_tprs_shaper.sv
// testbench for the transmit power ramp shaper
`timescale 1ns/100ps
`default_nettype none
module test_tprs_shaper;
  import tprs_pkg::*;
  logic       sys_clk, reset_n, tbl_wr_en, ask_mode, tx_active, sub_tick, tx_symbol;
  logic [2:0] tbl_wr_idx, ramp_top_index, cur_index;
  logic [7:0] tbl_wr_data, amp_setting_word, applied;
  int         error_cnt, cmp_count;

  tprs_shaper #(.N_ENTRIES(TPRS_ENTRIES)) i_tprs_shaper (.sys_clk, .reset_n, .tbl_wr_en, .tbl_wr_idx,
    .tbl_wr_data, .ramp_top_index, .ask_mode, .tx_active, .sub_tick, .tx_symbol, .amp_setting_word, .cur_index);
  tprs_pa_model i_tprs_pa_model (.sys_clk, .pwr_word(amp_setting_word), .applied);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one step pulse, then one more edge so the amplifier has taken it
  task automatic tick(input logic sym);
    @(negedge sys_clk); sub_tick = 1'b1; tx_symbol = sym;
    @(negedge sys_clk); sub_tick = 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic chk_sel(input int e);
    chk({5'h00, cur_index}, e[7:0]);
    chk(applied, 8'h10 + e[7:0]);
  endtask

  task automatic t_reset;
    @(negedge sys_clk);
    chk(applied, TPRS_PWR_RESET);
    chk({5'h00, cur_index}, 8'h00);
  endtask

  task automatic t_load;
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk); tbl_wr_en = 1'b1; tbl_wr_idx = i[2:0]; tbl_wr_data = 8'h10 + i[7:0];
    end
    @(negedge sys_clk); tbl_wr_en = 1'b0;
    @(negedge sys_clk);
    chk_sel(0);
  endtask

  task automatic t_ramp(input int top);
    ramp_top_index = top[2:0];
    tx_active = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk_sel(0);
    for (int j = 1; j <= top + 1; j++) begin
      tick(1'b1);
      chk_sel(j > top ? top : j);
    end
    tx_active = 1'b0;
    for (int j = 1; j <= top + 1; j++) begin
      tick(1'b1);
      chk_sel(top - j < 0 ? 0 : top - j);
    end
  endtask

  task automatic t_ask;
    int e;
    e = 0;
    ramp_top_index = 3'h7;
    ask_mode = 1'b1;
    for (int j = 0; j < 18; j++) begin
      tick(j < 9);
      e = (j < 9) ? (e < 7 ? e + 1 : 7) : (e > 0 ? e - 1 : 0);
      chk_sel(e);
    end
    ramp_top_index = 3'h3;
    repeat (4) tick(1'b1);
    repeat (4) @(negedge sys_clk);
    chk_sel(3);
    ramp_top_index = 3'h7;
    repeat (2) tick(1'b1);
    chk_sel(5);
    ramp_top_index = 3'h3;
    tick(1'b1);
    chk_sel(3);
  endtask

  // mid-run reset must restore table entry 1, not just the output
  task automatic t_rerun;
    @(negedge sys_clk); reset_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk(amp_setting_word, TPRS_PWR_RESET);
    reset_n = 1'b1;
    @(negedge sys_clk);
    chk(applied, TPRS_PWR_RESET);
    chk({5'h00, cur_index}, 8'h00);
    tick(1'b1);
    chk({5'h00, cur_index}, 8'h01);
    chk(applied, TPRS_PWR_RESET);
  endtask

  initial begin
    {reset_n, tbl_wr_en, ask_mode, tx_active, sub_tick, tx_symbol} = '0;
    {tbl_wr_idx, ramp_top_index, tbl_wr_data} = '0;
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
    t_reset();
    t_load();
    t_ramp(7);
    t_ramp(0);
    t_ask();
    t_rerun();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_sim();
  end
endmodule // test_tprs_shaper
`default_nettype wire
